/* File: design/debug_access_security_and_run_control.sv */
// service bus security filter, debug run control, mailbox and memory service unit
`timescale 1ns/1ps
module debug_access_security_and_run_control
   import dbg_access_pkg::*;
#(
   parameter int NUM_PBP = 6,
   parameter int NUM_DBP = 2
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [35:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic ack_o,
   output logic err_o,
   input wire logic security_bit_i,
   input wire logic user_code_protect_flag_i,
   input wire logic [31:0] boot_region_size_i,
   input wire logic [31:0] flash_size_i,
   input wire logic [31:0] cpu_pc_i,
   input wire logic cpu_exec_i,
   input wire logic [31:0] cpu_sr_i,
   input wire logic [31:0] cpu_data_addr_i,
   input wire logic cpu_data_acc_i,
   input wire logic cpu_bkpt_insn_i,
   input wire logic cpu_debug_ret_i,
   input wire logic cpu_priv_i,
   input wire logic cpu_dr_req_i,
   input wire logic cpu_dr_we_i,
   input wire logic [11:0] cpu_dr_addr_i,
   input wire logic [31:0] cpu_dr_wdata_i,
   output logic [31:0] cpu_dr_rdata_o,
   output logic cpu_dr_ack_o,
   output logic cpu_dr_err_o,
   output logic cpu_halt_o,
   output logic cpu_debug_mode_o,
   output logic cpu_monitor_o,
   output logic [31:0] dinst_data_o,
   output logic dinst_valid_o,
   output logic mem_cyc_o,
   output logic mem_we_o,
   output logic [31:0] mem_adr_o,
   output logic [31:0] mem_dat_o,
   output logic [3:0] mem_sel_o,
   input wire logic mem_ack_i,
   input wire logic [31:0] mem_dat_i,
   input wire logic trace_valid_i,
   input wire logic [31:0] trace_data_i,
   output logic trace_ready_o
);
   localparam int NUM_BP = NUM_PBP + NUM_DBP;

   bus_state_t state_reg;
   logic [3:0] slave;
   logic svc_req, permit, mapped, to_mem, svc_reg, in_flash;
   logic lock, can_enter, trigger, pbp_hit, dbp_hit, ubreak;
   logic [NUM_BP-1:0] hit;
   logic [31:0] bp_addr_reg [NUM_BP];
   logic [NUM_BP-1:0] bp_en_reg;
   logic monitor_reg, debug_reg, mon_active_reg;
   logic [31:0] ret_addr_reg, ret_stat_reg;
   logic [31:0] c2d_reg, d2c_reg;
   logic c2d_full_reg, d2c_full_reg;
   reg_access_t acc;
   logic acc_v, acc_cpu, cpu_ok;
   logic [31:0] dbg_rd, ms_rd;
   logic [31:0] ms_base_reg, ms_size_reg, crc_reg, crc_res_reg, ptr_reg;
   logic trace_en_reg, crc_busy_reg, wrapped_reg, ms_wr;

   // ***********************
   // service bus decode and security filter
   // ***********************
   assign slave = adr_i[35:32];
   assign svc_req = cyc_i & stb_i & ~ack_o & ~err_o & (state_reg == ST_IDLE);
   assign lock = security_bit_i & user_code_protect_flag_i;
   assign in_flash = (adr_i >= FLASH_BASE + {4'h0, boot_region_size_i})
                   && (adr_i < FLASH_BASE + {4'h0, flash_size_i});
   // every access judged on its own address, no memory of earlier ones
   always_comb begin
      if (!security_bit_i) begin
         permit = 1'b1;
      end else begin
         permit = (adr_i >= MBOX_LO && adr_i <= MBOX_HI)
                || (adr_i >= USER_LO && adr_i < USER_HI && !we_i)
                || (user_code_protect_flag_i && adr_i >= FCTL_LO && adr_i < FCTL_HI)
                || (user_code_protect_flag_i && in_flash);
      end
   end
   assign mapped = (slave == SLV_DEBUG) || (slave == SLV_MEM_A) || (slave == SLV_MEM_B)
                 || (slave == SLV_MEMSVC);
   assign to_mem = (slave == SLV_MEM_A) || (slave == SLV_MEM_B);
   assign svc_reg = svc_req & permit & mapped & ~to_mem;

   // ***********************
   // bus sequencer: forwarding, crc reads, trace writes
   // ***********************
   // service requests win over crc and trace so the debugger is never starved
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= ST_IDLE;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (svc_req && permit && to_mem) begin
                  state_reg <= ST_MEM_FWD;
               end else if (!(cyc_i && stb_i) && crc_busy_reg) begin
                  state_reg <= ST_CRC_RD;
               end else if (!(cyc_i && stb_i) && trace_en_reg && trace_valid_i) begin
                  state_reg <= ST_TRACE_WR;
               end
            end
            ST_MEM_FWD, ST_CRC_RD, ST_TRACE_WR: begin
               if (mem_ack_i) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
   // memory master signals follow the state; addresses held while waiting
   always_comb begin
      mem_cyc_o = state_reg != ST_IDLE;
      mem_we_o = 1'b0;
      mem_adr_o = adr_i[31:0];
      mem_dat_o = dat_i;
      mem_sel_o = sel_i;
      case (state_reg)
         ST_MEM_FWD: mem_we_o = we_i;
         ST_CRC_RD: begin
            mem_adr_o = ms_base_reg + ptr_reg;
            mem_sel_o = 4'hf;
         end
         ST_TRACE_WR: begin
            mem_we_o = 1'b1;
            mem_adr_o = ms_base_reg + ptr_reg;
            mem_dat_o = trace_data_i;
            mem_sel_o = 4'hf;
         end
         default: mem_cyc_o = 1'b0;
      endcase
   end
   assign trace_ready_o = (state_reg == ST_TRACE_WR) & mem_ack_i;

   // answer to the service master: one cycle after the request for registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
         dat_o <= RST_WORD;
      end else begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
         if (svc_req && !(permit && mapped)) begin
            err_o <= 1'b1;
            dat_o <= BLOCKED_RDATA;
         end else if (svc_reg) begin
            ack_o <= 1'b1;
            dat_o <= (slave == SLV_DEBUG) ? dbg_rd : ms_rd;
         end else if (state_reg == ST_MEM_FWD && mem_ack_i) begin
            ack_o <= 1'b1;
            dat_o <= mem_dat_i;
         end
      end
   end

   // ***********************
   // debug register access arbitration
   // ***********************
   // the service bus has priority; a cpu access simply waits a cycle
   assign cpu_ok = cpu_dr_req_i & ~cpu_dr_ack_o & ~cpu_dr_err_o
                 & ~(svc_reg & (slave == SLV_DEBUG));
   always_comb begin
      acc_v = 1'b0;
      acc_cpu = 1'b0;
      acc = '{we: we_i, off: adr_i[11:0], wdata: dat_i, sel: sel_i};
      if (svc_reg && slave == SLV_DEBUG) begin
         acc_v = 1'b1;
      end else if (cpu_ok && cpu_priv_i) begin
         acc_v = 1'b1;
         acc_cpu = 1'b1;
         acc = '{we: cpu_dr_we_i, off: cpu_dr_addr_i, wdata: cpu_dr_wdata_i, sel: 4'hf};
      end
   end
   // cpu answer; an unprivileged attempt is refused and changes nothing
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cpu_dr_ack_o <= 1'b0;
         cpu_dr_err_o <= 1'b0;
         cpu_dr_rdata_o <= RST_WORD;
      end else begin
         cpu_dr_ack_o <= acc_v & acc_cpu;
         cpu_dr_err_o <= cpu_ok & ~cpu_priv_i;
         if (acc_v && acc_cpu) begin
            cpu_dr_rdata_o <= dbg_rd;
         end
      end
   end
   // debug register read mux
   always_comb begin
      dbg_rd = RST_WORD;
      case (acc.off)
         OFF_DEV_CTRL: dbg_rd = {30'h0, 1'b0, monitor_reg};
         OFF_DEV_STAT: dbg_rd = {29'h0, cpu_halt_o, mon_active_reg, debug_reg};
         OFF_DBG_PC: dbg_rd = cpu_pc_i;
         OFF_DBG_INSN: dbg_rd = dinst_data_o;
         OFF_RET_ADDR: dbg_rd = ret_addr_reg;
         OFF_RET_STAT: dbg_rd = ret_stat_reg;
         OFF_BP_EN: dbg_rd = {{(32-NUM_BP){1'b0}}, bp_en_reg};
         OFF_MBOX_C2D: dbg_rd = c2d_reg;
         OFF_MBOX_D2C: dbg_rd = d2c_reg;
         OFF_MBOX_STAT: dbg_rd = {30'h0, d2c_full_reg, c2d_full_reg};
         default: begin
            for (int i = 0; i < NUM_BP; i++) begin
               if (acc.off == OFF_BP_BASE + 12'(4 * i)) begin
                  dbg_rd = bp_addr_reg[i];
               end
            end
         end
      endcase
   end

   // ***********************
   // breakpoint comparators
   // ***********************
   genvar g;
   generate
      for (g = 0; g < NUM_BP; g++) begin : g_bp
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               bp_addr_reg[g] <= RST_WORD;
            end else if (acc_v && acc.we && acc.off == OFF_BP_BASE + 12'(4 * g)) begin
               bp_addr_reg[g] <= lane_merge(bp_addr_reg[g], acc.wdata, acc.sel);
            end
         end
         if (g < NUM_PBP) begin : g_prog
            assign hit[g] = bp_en_reg[g] & cpu_exec_i & (cpu_pc_i == bp_addr_reg[g]);
         end else begin : g_data
            assign hit[g] = bp_en_reg[g] & cpu_data_acc_i
                          & (cpu_data_addr_i[31:2] == bp_addr_reg[g][31:2]);
         end
      end
   endgenerate
   assign pbp_hit = |hit[NUM_PBP-1:0];
   assign dbp_hit = |hit[NUM_BP-1:NUM_PBP];

   // control, enables and instruction register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         monitor_reg <= 1'b0;
         bp_en_reg <= '0;
         dinst_data_o <= RST_WORD;
         dinst_valid_o <= 1'b0;
      end else begin
         dinst_valid_o <= 1'b0;
         if (acc_v && acc.we && acc.off == OFF_DEV_CTRL && acc.sel[0]) begin
            monitor_reg <= acc.wdata[CTRL_MONITOR];
         end
         if (acc_v && acc.we && acc.off == OFF_BP_EN && acc.sel[0]) begin
            bp_en_reg <= acc.wdata[NUM_BP-1:0];
         end
         if (acc_v && !acc_cpu && acc.we && acc.off == OFF_DBG_INSN) begin
            dinst_data_o <= lane_merge(dinst_data_o, acc.wdata, acc.sel);
            dinst_valid_o <= cpu_halt_o;
         end
      end
   end

   // ***********************
   // run control
   // ***********************
   assign ubreak = acc_v & ~acc_cpu & acc.we & (acc.off == OFF_DEV_CTRL) & acc.sel[0]
                 & acc.wdata[CTRL_UBREAK];
   // protected code may only debug itself through the monitor
   assign can_enter = ~debug_reg & (~lock | monitor_reg);
   assign trigger = can_enter & (ubreak | pbp_hit | dbp_hit | cpu_bkpt_insn_i);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         debug_reg <= 1'b0;
         mon_active_reg <= 1'b0;
         ret_addr_reg <= RST_WORD;
         ret_stat_reg <= RST_WORD;
      end else if (trigger) begin
         debug_reg <= 1'b1;
         mon_active_reg <= monitor_reg;
         ret_addr_reg <= cpu_pc_i;
         ret_stat_reg <= cpu_sr_i;
      end else if (cpu_debug_ret_i) begin
         debug_reg <= 1'b0;
         mon_active_reg <= 1'b0;
      end
   end
   assign cpu_debug_mode_o = debug_reg;
   assign cpu_halt_o = debug_reg & ~mon_active_reg;
   assign cpu_monitor_o = mon_active_reg;

   // ***********************
   // mailbox
   // ***********************
   // a full flag is set by the writer and cleared by the reader's read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         c2d_reg <= RST_WORD;
         d2c_reg <= RST_WORD;
         c2d_full_reg <= 1'b0;
         d2c_full_reg <= 1'b0;
      end else if (acc_v) begin
         if (acc.we && acc_cpu && acc.off == OFF_MBOX_C2D) begin
            c2d_reg <= acc.wdata;
            c2d_full_reg <= 1'b1;
         end else if (!acc.we && !acc_cpu && acc.off == OFF_MBOX_C2D) begin
            c2d_full_reg <= 1'b0;
         end
         if (acc.we && !acc_cpu && acc.off == OFF_MBOX_D2C) begin
            d2c_reg <= lane_merge(d2c_reg, acc.wdata, acc.sel);
            d2c_full_reg <= 1'b1;
         end else if (!acc.we && acc_cpu && acc.off == OFF_MBOX_D2C) begin
            d2c_full_reg <= 1'b0;
         end
      end
   end

   // ***********************
   // memory service unit
   // ***********************
   assign ms_wr = svc_reg & we_i & (slave == SLV_MEMSVC);
   always_comb begin
      case (adr_i[11:0])
         OFF_MS_CTRL: ms_rd = {30'h0, trace_en_reg, 1'b0};
         OFF_MS_STAT: ms_rd = {30'h0, wrapped_reg, crc_busy_reg};
         OFF_MS_BASE: ms_rd = ms_base_reg;
         OFF_MS_SIZE: ms_rd = ms_size_reg;
         OFF_MS_CRC: ms_rd = crc_res_reg;
         OFF_MS_TPTR: ms_rd = ptr_reg;
         default: ms_rd = RST_WORD;
      endcase
   end
   // ptr walks the block for crc and the ring for trace; wrap limits it to size
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ms_base_reg <= RST_WORD;
         ms_size_reg <= RST_WORD;
         trace_en_reg <= 1'b0;
         crc_busy_reg <= 1'b0;
         wrapped_reg <= 1'b0;
         ptr_reg <= RST_WORD;
         crc_reg <= CRC_INIT;
         crc_res_reg <= RST_WORD;
      end else begin
         if (ms_wr && adr_i[11:0] == OFF_MS_BASE) begin
            ms_base_reg <= lane_merge(ms_base_reg, dat_i, sel_i);
         end
         if (ms_wr && adr_i[11:0] == OFF_MS_SIZE) begin
            ms_size_reg <= lane_merge(ms_size_reg, dat_i, sel_i);
         end
         if (ms_wr && adr_i[11:0] == OFF_MS_CTRL && sel_i[0]) begin
            trace_en_reg <= dat_i[MS_TRACE_EN] && ms_size_reg != RST_WORD;
            crc_busy_reg <= dat_i[MS_CRC_GO] && ms_size_reg != RST_WORD;
            ptr_reg <= RST_WORD;
            wrapped_reg <= 1'b0;
            crc_reg <= CRC_INIT;
         end else if (state_reg == ST_CRC_RD && mem_ack_i) begin
            crc_reg <= crc_word(crc_reg, mem_dat_i);
            ptr_reg <= ptr_reg + WORD_STEP;
            if (ptr_reg + WORD_STEP >= ms_size_reg) begin
               crc_busy_reg <= 1'b0;
               crc_res_reg <= ~crc_word(crc_reg, mem_dat_i);
            end
         end else if (state_reg == ST_TRACE_WR && mem_ack_i) begin
            if (ptr_reg + WORD_STEP >= ms_size_reg) begin
               ptr_reg <= RST_WORD;
               wrapped_reg <= 1'b1;
            end else begin
               ptr_reg <= ptr_reg + WORD_STEP;
            end
         end
      end
   end

   // ***********************
   // checks
   // ***********************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_blocked_access: assert property (svc_req && !permit |=> err_o && !ack_o && dat_o == BLOCKED_RDATA) else $error("blocked access not refused");
   chk_secure_readonly: assert property (security_bit_i && !user_code_protect_flag_i
      && svc_req && we_i && to_mem |=> state_reg == ST_IDLE && !mem_cyc_o) else $error("secure write reached memory");
   chk_ctl_window: assert property (lock && svc_req && adr_i >= FCTL_LO && adr_i < FCTL_HI
      |=> state_reg == ST_MEM_FWD) else $error("controller window not passed");
   chk_ubreak_halt: assert property (ubreak && !debug_reg && !lock |=> cpu_debug_mode_o) else $error("unconditional break did not halt");
   chk_pbp_save: assert property (pbp_hit && can_enter |=> debug_reg && ret_addr_reg == $past(cpu_pc_i)) else $error("program breakpoint entry wrong");
   chk_dbp_halt: assert property (dbp_hit && can_enter |=> debug_reg) else $error("data breakpoint missed");
   chk_swbp_halt: assert property (cpu_bkpt_insn_i && can_enter |=> $rose(cpu_debug_mode_o)) else $error("breakpoint instruction missed");
   chk_lock_no_halt: assert property (lock && !monitor_reg && !debug_reg |=> !cpu_halt_o) else $error("debugger took control under protection");
   chk_monitor_entry: assert property (trigger && monitor_reg |=> cpu_monitor_o && !cpu_halt_o) else $error("monitor mode not entered");
   chk_insn_exec: assert property (dinst_valid_o |-> cpu_halt_o) else $error("instruction issued outside halt");
   chk_priv_refuse: assert property (cpu_ok && !cpu_priv_i |=> cpu_dr_err_o && !cpu_dr_ack_o) else $error("unprivileged access not refused");
   chk_mbox_full: assert property (acc_v && !acc_cpu && acc.we && acc.off == OFF_MBOX_D2C |=> d2c_full_reg) else $error("mailbox flag not set");
   cov_break_halt: cover property (pbp_hit ##1 cpu_halt_o ##[1:20] dinst_valid_o);
   cov_blocked: cover property (svc_req && !permit ##1 err_o);
   cov_crc_done: cover property (crc_busy_reg ##[1:200] !crc_busy_reg);
   cov_trace_wrap: cover property (!wrapped_reg ##1 wrapped_reg);
endmodule : debug_access_security_and_run_control

/* File: design/dbg_access_pkg.sv */
// constants, layouts and types shared by the debug access and run control block
package dbg_access_pkg;
   // ***********************
   // service bus geometry
   // ***********************
   localparam int SVC_ADDR_W = 36;
   localparam logic [3:0] SLV_DEBUG = 4'h1;
   localparam logic [3:0] SLV_MEM_A = 4'h4;
   localparam logic [3:0] SLV_MEM_B = 4'h5;
   localparam logic [3:0] SLV_MEMSVC = 4'h6;
   // ***********************
   // security windows
   // ***********************
   localparam logic [35:0] MBOX_LO = 36'h100000110;
   localparam logic [35:0] MBOX_HI = 36'h100000118;
   localparam logic [35:0] USER_LO = 36'h580800000;
   localparam logic [35:0] USER_HI = 36'h581000000;
   localparam logic [35:0] FCTL_LO = 36'h5fffe0000;
   localparam logic [35:0] FCTL_HI = 36'h5fffe0400;
   localparam logic [35:0] FLASH_BASE = 36'h580000000;
   localparam logic [31:0] BLOCKED_RDATA = 32'h00000000;
   // ***********************
   // debug register offsets
   // ***********************
   localparam logic [11:0] OFF_DEV_CTRL = 12'h000;
   localparam logic [11:0] OFF_DEV_STAT = 12'h004;
   localparam logic [11:0] OFF_DBG_PC = 12'h008;
   localparam logic [11:0] OFF_DBG_INSN = 12'h00c;
   localparam logic [11:0] OFF_RET_ADDR = 12'h010;
   localparam logic [11:0] OFF_RET_STAT = 12'h014;
   localparam logic [11:0] OFF_BP_BASE = 12'h020;
   localparam logic [11:0] OFF_BP_EN = 12'h040;
   localparam logic [11:0] OFF_MBOX_C2D = 12'h110;
   localparam logic [11:0] OFF_MBOX_D2C = 12'h114;
   localparam logic [11:0] OFF_MBOX_STAT = 12'h118;
   // control bits
   localparam int CTRL_MONITOR = 0;
   localparam int CTRL_UBREAK = 1;
   // ***********************
   // memory service offsets
   // ***********************
   localparam logic [11:0] OFF_MS_CTRL = 12'h000;
   localparam logic [11:0] OFF_MS_STAT = 12'h004;
   localparam logic [11:0] OFF_MS_BASE = 12'h008;
   localparam logic [11:0] OFF_MS_SIZE = 12'h00c;
   localparam logic [11:0] OFF_MS_CRC = 12'h010;
   localparam logic [11:0] OFF_MS_TPTR = 12'h014;
   localparam int MS_CRC_GO = 0;
   localparam int MS_TRACE_EN = 1;
   // ***********************
   // reset values and crc
   // ***********************
   localparam logic [31:0] RST_WORD = 32'h00000000;
   localparam logic [31:0] CRC_INIT = 32'hffffffff;
   localparam logic [31:0] CRC_POLY = 32'hedb88320;
   localparam logic [31:0] WORD_STEP = 32'h00000004;
   // ***********************
   // types
   // ***********************
   typedef struct packed {
      logic we;
      logic [11:0] off;
      logic [31:0] wdata;
      logic [3:0] sel;
   } reg_access_t;
   typedef enum {ST_IDLE, ST_MEM_FWD, ST_CRC_RD, ST_TRACE_WR} bus_state_t;
   // byte-lane merge for partial writes
   function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r;
   endfunction : lane_merge
   // one word into a reflected crc32
   function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] d);
      logic [31:0] r;
      r = c ^ d;
      for (int i = 0; i < 32; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : crc_word
endpackage : dbg_access_pkg

/* File: testbench/mem_slave_model.sv */
// memory slave model standing behind the block's memory master port
`timescale 1ns/1ps
module mem_slave_model (
   input wire logic clk_i,
   input wire logic mem_cyc_i,
   input wire logic [31:0] mem_adr_i,
   output logic mem_ack_o,
   output logic [31:0] mem_dat_o
);
   logic [1:0] wait_reg = 2'h0;
   initial mem_ack_o = 1'b0;
   initial mem_dat_o = 32'h00000000;
   // slow answer after wait states; data toggles when not acked so stale values never match
   always @(posedge clk_i) begin
      mem_ack_o <= 1'b0;
      mem_dat_o <= ~mem_dat_o;
      if (mem_cyc_i && !mem_ack_o) begin
         wait_reg <= wait_reg + 2'h1;
         if (wait_reg == 2'h2) begin
            mem_ack_o <= 1'b1;
            mem_dat_o <= ~mem_adr_i;
            wait_reg <= 2'h0;
         end
      end
   end
endmodule : mem_slave_model

/* File: testbench/test_debug_access_security_and_run_control.sv */
// self-checking bench for the debug access and run control block
`timescale 1ns/1ps
module test_debug_access_security_and_run_control;
   import dbg_access_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
   logic security_bit_i = 1'b0, user_code_protect_flag_i = 1'b0, cpu_exec_i = 1'b0;
   logic cpu_data_acc_i = 1'b0, cpu_bkpt_insn_i = 1'b0, cpu_debug_ret_i = 1'b0;
   logic cpu_priv_i = 1'b1, cpu_dr_req_i = 1'b0, cpu_dr_we_i = 1'b0, trace_valid_i = 1'b0;
   logic [3:0] sel_i = 4'hf, mem_sel_o;
   logic [11:0] cpu_dr_addr_i = 12'h000;
   logic [35:0] adr_i = 36'h000000000;
   logic [31:0] dat_i = 32'h0, boot_region_size_i = 32'h1000, flash_size_i = 32'h40000;
   logic [31:0] cpu_pc_i = 32'h124, cpu_sr_i = 32'h0, cpu_data_addr_i = 32'h0;
   logic [31:0] cpu_dr_wdata_i = 32'h0, trace_data_i = 32'h0, q;
   logic [31:0] dat_o, cpu_dr_rdata_o, dinst_data_o, mem_adr_o, mem_dat_o, mem_dat_i;
   logic ack_o, err_o, cpu_dr_ack_o, cpu_dr_err_o, cpu_halt_o, cpu_debug_mode_o;
   logic cpu_monitor_o, dinst_valid_o, mem_cyc_o, mem_we_o, mem_ack_i, trace_ready_o;
   logic [1:0] r;
   logic p;
   int fail_count = 0, check_count = 0;
   debug_access_security_and_run_control i_debug_access_security_and_run_control (.*);
   mem_slave_model i_mem_slave_model (.clk_i(clk_i), .mem_cyc_i(mem_cyc_o),
      .mem_adr_i(mem_adr_o), .mem_ack_o(mem_ack_i), .mem_dat_o(mem_dat_i));
   always #2.5 clk_i = ~clk_i;
   // one classic cycle; resp bit0 ack, bit1 error; p is the issue pulse at the answer edge
   task automatic wb(input logic w, input logic [35:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      // no limit of its own: a hung access is ended by the watchdog
      do begin
         @(posedge clk_i);
      end while (!(ack_o | err_o));
      q = dat_o;
      r = {err_o, ack_o};
      p = dinst_valid_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // cpu side debug register access; holds the request until ack or error
   task automatic cpu_acc(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cpu_dr_req_i <= 1'b1;
      cpu_dr_we_i <= w;
      cpu_dr_addr_i <= a;
      cpu_dr_wdata_i <= d;
      do begin
         @(posedge clk_i);
      end while (!(cpu_dr_ack_o | cpu_dr_err_o));
      q = cpu_dr_rdata_o;
      r = {cpu_dr_err_o, cpu_dr_ack_o};
      cpu_dr_req_i <= 1'b0;
      @(posedge clk_i);
   endtask : cpu_acc
   // one trace word; the memory write is looked at in the cycle it is acknowledged
   task automatic trace_put(input logic [31:0] d, input logic [31:0] a);
      @(posedge clk_i);
      trace_valid_i <= 1'b1;
      trace_data_i <= d;
      do begin
         @(posedge clk_i);
      end while (!trace_ready_o);
      chk(mem_dat_o, d);
      chk(mem_adr_o, a);
      chk({31'h0, mem_we_o}, 32'h1);
      trace_valid_i <= 1'b0;
      @(posedge clk_i);
   endtask : trace_put
   // bench's own reflected crc32 step over one word
   function automatic logic [31:0] ref_crc(input logic [31:0] c, input logic [31:0] d);
      logic [31:0] x;
      x = c ^ d;
      for (int i = 0; i < 32; i++) begin
         x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
      end
      return x;
   endfunction : ref_crc
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out
   // the whole sequence takes a few hundred cycles
   initial begin
      #20000;
      fail_count++;
      close_out();
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      // open device: mailbox handshake, live pc, unconditional break
      wb(1'b1, 36'h100000114, 32'h5a5a0001);
      wb(1'b0, 36'h100000118, 32'h0);
      chk(q & 32'h2, 32'h2);
      wb(1'b0, 36'h100000114, 32'h0);
      chk(q, 32'h5a5a0001);
      wb(1'b0, 36'h100000008, 32'h0);
      chk(q, cpu_pc_i);
      wb(1'b1, 36'h100000000, 32'h2);
      chk({30'h0, cpu_halt_o, cpu_debug_mode_o}, 32'h3);
      wb(1'b0, 36'h100000004, 32'h0);
      chk(q & 32'h5, 32'h5);
      // halted: each debugger write of the instruction register issues it once
      wb(1'b1, 36'h10000000c, 32'h0000abcd);
      chk({p, dinst_data_o[30:0]}, 32'h8000abcd);
      // secured: only mailbox and user page read pass; blocked ones change nothing
      security_bit_i <= 1'b1;
      wb(1'b0, 36'h100000110, 32'h0);
      chk({30'h0, r}, 32'h1);
      wb(1'b1, 36'h100000020, 32'h1234);
      chk({30'h0, r}, 32'h2);
      wb(1'b0, 36'h100000008, 32'h0);
      chk({q[29:0], r}, 32'h2);
      wb(1'b0, 36'h580800000, 32'h0);
      chk({q[29:0], r}, 32'hfdfffffd);
      wb(1'b1, 36'h580800000, 32'h0);
      chk({30'h0, r}, 32'h2);
      // protect flag adds controller window and flash above the boot region
      user_code_protect_flag_i <= 1'b1;
      wb(1'b0, 36'h5fffe0000, 32'h0);
      chk({30'h0, r}, 32'h1);
      wb(1'b0, 36'h580001000, 32'h0);
      chk({30'h0, r}, 32'h1);
      wb(1'b0, 36'h580000ffc, 32'h0);
      chk({30'h0, r}, 32'h2);
      security_bit_i <= 1'b0;
      user_code_protect_flag_i <= 1'b0;
      wb(1'b0, 36'h100000020, 32'h0);
      chk(q, RST_WORD);
      // unsecured, an unallocated slave is still refused
      wb(1'b0, 36'h200000000, 32'h0);
      chk({30'h0, r}, 32'h2);
      // cpu side: refused unless privileged, then mailbox towards the debugger
      cpu_priv_i <= 1'b0;
      cpu_acc(1'b1, OFF_MBOX_C2D, 32'h0);
      chk({30'h0, r}, 32'h2);
      cpu_priv_i <= 1'b1;
      cpu_acc(1'b1, OFF_MBOX_C2D, 32'hc0de0002);
      wb(1'b0, 36'h100000110, 32'h0);
      chk(q, 32'hc0de0002);
      cpu_acc(1'b0, OFF_RET_ADDR, 32'h0);
      chk(q, 32'h124);
      // leave debug state, then a breakpoint instruction with monitor mode set
      cpu_debug_ret_i <= 1'b1;
      @(posedge clk_i);
      cpu_debug_ret_i <= 1'b0;
      wb(1'b1, 36'h100000000, 32'h1);
      cpu_bkpt_insn_i <= 1'b1;
      @(posedge clk_i);
      cpu_bkpt_insn_i <= 1'b0;
      @(posedge clk_i);
      chk({29'h0, cpu_monitor_o, cpu_halt_o, cpu_debug_mode_o}, 32'h5);
      cpu_debug_ret_i <= 1'b1;
      @(posedge clk_i);
      cpu_debug_ret_i <= 1'b0;
      wb(1'b1, 36'h100000000, 32'h0);
      // program comparator 0 and data comparator 7
      wb(1'b1, 36'h100000020, 32'h00000200);
      wb(1'b1, 36'h10000003c, 32'h00001000);
      wb(1'b1, 36'h100000040, 32'h00000081);
      cpu_pc_i <= 32'h200;
      cpu_exec_i <= 1'b1;
      @(posedge clk_i);
      cpu_exec_i <= 1'b0;
      wb(1'b0, 36'h100000010, 32'h0);
      chk({q[30:0], cpu_debug_mode_o}, 32'h401);
      cpu_debug_ret_i <= 1'b1;
      @(posedge clk_i);
      cpu_debug_ret_i <= 1'b0;
      cpu_pc_i <= 32'h300;
      cpu_data_addr_i <= 32'h1002;
      cpu_data_acc_i <= 1'b1;
      @(posedge clk_i);
      cpu_data_acc_i <= 1'b0;
      wb(1'b0, 36'h100000010, 32'h0);
      chk({q[30:0], cpu_debug_mode_o}, 32'h601);
      // crc over two words; the memory model answers with the inverted address
      wb(1'b1, 36'h600000008, 32'h00000100);
      wb(1'b1, 36'h60000000c, 32'h00000008);
      wb(1'b1, 36'h600000000, 32'h00000001);
      do begin
         wb(1'b0, 36'h600000004, 32'h0);
      end while (q[0]);
      wb(1'b0, 36'h600000010, 32'h0);
      chk(q, ~ref_crc(ref_crc(CRC_INIT, 32'hfffffeff), 32'hfffffefb));
      // trace ring of two words wraps back to its base
      wb(1'b1, 36'h600000000, 32'h00000002);
      trace_put(32'hc0ffee01, 32'h00000100);
      trace_put(32'hc0ffee02, 32'h00000104);
      wb(1'b0, 36'h600000004, 32'h0);
      chk(q, 32'h2);
      close_out();
   end
endmodule : test_debug_access_security_and_run_control
